// ===== uef_event_flags.sv
// usb device global event flags, frame counters and wishbone registers
//
// Implementation choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ns
module uef_event_flags #(
   parameter int SUSPEND_CYCLES = uef_pkg::SUSPEND_CYCLES,
   parameter int FILTER_CYCLES = uef_pkg::FILTER_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic [uef_pkg::ADR_W-1:0] adr_i,
   input wire logic [uef_pkg::DAT_W-1:0] dat_i,
   output logic [uef_pkg::DAT_W-1:0] dat_o,
   input wire logic we_i,
   input wire logic [uef_pkg::SEL_W-1:0] sel_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic ack_o,
   // link side events
   input wire logic high_speed_i,
   input wire logic resume_end_i,
   input wire logic line_activity_i,
   input wire logic upstream_resume_i,
   input wire logic bus_reset_done_i,
   input wire logic sof_token_i,
   input wire logic [uef_pkg::FRAME_NUMBER_W-1:0] sof_frame_i,
   input wire logic line_idle_j_i,
   // system side
   output logic port_clock_hold_o,
   output logic irq_o
);
   import uef_pkg::*;

   function automatic logic reg_hit(input logic [ADR_W-1:0] a, input logic [7:0] ofs);
      reg_hit = (a == ofs);
   endfunction : reg_hit

   function automatic logic flag_next(input logic cur, input logic set, input logic clr);
      // a set in the clearing cycle wins
      flag_next = set | (cur & ~clr);
   endfunction : flag_next

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic [FLAG_W-1:0] flags_r;
   logic [FLAG_W-1:0] mask_r;
   logic [FRAME_NUMBER_W-1:0] frame_number_r;
   logic [MICROFRAME_INDEX_W-1:0] microframe_index_r;
   logic frame_seen_r;
   logic hold_r;
   logic ack_r;
   logic [DAT_W-1:0] rdata_r;

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   wire req = cyc_i & stb_i & ~ack_r;
   wire wr_lo = req & we_i & sel_i[0];
   wire wr_clear = wr_lo & reg_hit(adr_i, OFS_CLEAR);
   wire wr_mask = wr_lo & reg_hit(adr_i, OFS_MASK);
   wire wr_ctrl = wr_lo & reg_hit(adr_i, OFS_CTRL);
   // only ones act; zero bits leave their flag alone
   wire [FLAG_W-1:0] ack_bits = wr_clear ? dat_i[FLAG_W-1:0] : '0;

   // ---------------------------------------------------------------
   // event detection
   // ---------------------------------------------------------------
   logic wake_rise;
   logic idle_expired;

   uef_line_filter #(
      .LEN(FILTER_CYCLES)
   ) u_filter (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .active_i(line_activity_i),
      .rise_o(wake_rise)
   );

   uef_idle_timer #(
      .CYCLES(SUSPEND_CYCLES)
   ) u_idle (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .idle_i(line_idle_j_i),
      .expired_o(idle_expired)
   );

   // wake path is not gated by the clock hold, unlike every other event
   wire wake_evt = wake_rise & ~upstream_resume_i
                   & (flags_r[BIT_SLEEP] | hold_r);
   wire resume_evt = resume_end_i & ~hold_r;
   wire reset_evt = bus_reset_done_i & ~hold_r;
   wire sleep_evt = idle_expired & ~hold_r;
   wire sof_ok = sof_token_i & ~hold_r;
   // in high speed a token repeating the last frame number is a microframe
   wire same_frame = frame_seen_r & (sof_frame_i == frame_number_r);
   wire frame_evt = sof_ok & (~high_speed_i | ~same_frame);
   wire mframe_evt = sof_ok & high_speed_i & same_frame;

   // ---------------------------------------------------------------
   // flag set and clear vectors
   // ---------------------------------------------------------------
   logic [FLAG_W-1:0] set_vec;
   logic [FLAG_W-1:0] clr_vec;

   always_comb begin
      set_vec = '0;
      set_vec[BIT_RESUME] = resume_evt;
      set_vec[BIT_WAKE] = wake_evt;
      set_vec[BIT_RESET] = reset_evt;
      set_vec[BIT_FRAME] = frame_evt;
      set_vec[BIT_MFRAME] = mframe_evt;
      set_vec[BIT_SLEEP] = sleep_evt;
      clr_vec = ack_bits;
      // wake ack is refused while the port clock is held
      clr_vec[BIT_WAKE] = (ack_bits[BIT_WAKE] & ~hold_r) | sleep_evt;
      clr_vec[BIT_SLEEP] = ack_bits[BIT_SLEEP] | wake_evt;
   end

   genvar gi;
   generate
      for (gi = 0; gi < FLAG_W; gi++) begin : g_flag
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               flags_r[gi] <= FLAGS_RST[gi];
            end else begin
               flags_r[gi] <= flag_next(flags_r[gi], set_vec[gi], clr_vec[gi]);
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // frame and microframe numbers
   // ---------------------------------------------------------------
   wire [MICROFRAME_INDEX_W-1:0] mf_nxt = frame_evt & high_speed_i ? MICROFRAME_INDEX_RST
                             : mframe_evt ? microframe_index_r + MICROFRAME_INDEX_ONE
                             : microframe_index_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         frame_number_r <= FRAME_NUMBER_RST;
         microframe_index_r <= MICROFRAME_INDEX_RST;
         frame_seen_r <= 1'b0;
      end else begin
         // a microframe never touches the frame number
         if (frame_evt) begin
            frame_number_r <= sof_frame_i;
            frame_seen_r <= 1'b1;
         end
         microframe_index_r <= mf_nxt;
      end
   end

   // ---------------------------------------------------------------
   // mask, control and bus answer
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mask_r <= MASK_RST;
         hold_r <= HOLD_RST;
      end else begin
         if (wr_mask) begin
            mask_r <= dat_i[FLAG_W-1:0];
         end
         if (wr_ctrl) begin
            hold_r <= dat_i[CTRL_HOLD_BIT];
         end
      end
   end

   // clear register reads zero, as do unmapped addresses
   wire [DAT_W-1:0] rd_mux =
        reg_hit(adr_i, OFS_STATUS) ? DAT_W'(flags_r)
      : reg_hit(adr_i, OFS_MASK) ? DAT_W'(mask_r)
      : reg_hit(adr_i, OFS_FRAME) ? DAT_W'({frame_number_r, microframe_index_r})
      : reg_hit(adr_i, OFS_CTRL) ? DAT_W'(hold_r)
      : '0;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         rdata_r <= '0;
      end else begin
         ack_r <= req;
         if (req) begin
            rdata_r <= rd_mux;
         end
      end
   end

   assign ack_o = ack_r;
   assign dat_o = rdata_r;
   assign port_clock_hold_o = hold_r;
   assign irq_o = |(flags_r & mask_r);
endmodule : uef_event_flags

// ===== uef_pkg.sv
// constants, register map and timing for the usb device event flag block
package uef_pkg;
   // ---------------------------------------------------------------
   // flag positions, shared by status, clear and mask registers
   // ---------------------------------------------------------------
   localparam int FLAG_W = 6;
   localparam int BIT_SLEEP = 0;
   localparam int BIT_MFRAME = 1;
   localparam int BIT_FRAME = 2;
   localparam int BIT_RESET = 3;
   localparam int BIT_WAKE = 4;
   localparam int BIT_RESUME = 5;

   // ---------------------------------------------------------------
   // register map (byte addresses on the bus)
   // ---------------------------------------------------------------
   localparam int ADR_W = 8;
   localparam int DAT_W = 32;
   localparam int SEL_W = 4;
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_CLEAR = 8'h04;
   localparam logic [7:0] OFS_MASK = 8'h08;
   localparam logic [7:0] OFS_FRAME = 8'h0c;
   localparam logic [7:0] OFS_CTRL = 8'h10;
   localparam int FRAME_NUMBER_W = 11;
   localparam int MICROFRAME_INDEX_W = 3;
   localparam int FRAME_FRAME_NUMBER_LSB = MICROFRAME_INDEX_W;
   localparam int CTRL_HOLD_BIT = 0;
   localparam logic [FLAG_W-1:0] MASK_RST = 6'h00;
   localparam logic [FLAG_W-1:0] FLAGS_RST = 6'h00;
   localparam logic [FRAME_NUMBER_W-1:0] FRAME_NUMBER_RST = 11'h000;
   localparam logic [MICROFRAME_INDEX_W-1:0] MICROFRAME_INDEX_RST = 3'h0;
   localparam logic [MICROFRAME_INDEX_W-1:0] MICROFRAME_INDEX_ONE = 3'h1;
   localparam logic HOLD_RST = 1'b0;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_HZ = 25_000_000;
   localparam int FRAME_PERIOD_US = 1000;
   localparam int MFRAME_PERIOD_US = 125;
   localparam int SUSPEND_FRAMES = 3;
   localparam int SUSPEND_TIME_US = SUSPEND_FRAMES * FRAME_PERIOD_US;
   // least time: exact product, no rounding
   localparam int SUSPEND_CYCLES = (SUSPEND_TIME_US * (CLK_HZ / 1_000_000) + 0);
   localparam int FILTER_CYCLES = 4;
endpackage : uef_pkg

// ===== uef_line_filter.sv
// glitch filter on bus line activity, one pulse per filtered rise
`timescale 1ns/1ns
module uef_line_filter #(
   parameter int LEN = 4
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic active_i,
   output logic rise_o
);
   logic [$clog2(LEN+1)-1:0] cnt_r;
   logic stable_r;
   wire full = (cnt_r == ($clog2(LEN+1))'(LEN));

   // ---------------------------------------------------------------
   // activity must hold for LEN cycles to count
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r <= '0;
         stable_r <= 1'b0;
      end else begin
         cnt_r <= !active_i ? '0 : (full ? cnt_r : cnt_r + 1'b1);
         stable_r <= full;
      end
   end

   assign rise_o = full & ~stable_r;
endmodule : uef_line_filter

// ===== uef_idle_timer.sv
// counts idle J cycles, pulses once when the suspend time is reached
`timescale 1ns/1ns
module uef_idle_timer #(
   parameter int CYCLES = 75000
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic idle_i,
   output logic expired_o
);
   localparam int CW = $clog2(CYCLES + 1);
   logic [CW-1:0] cnt_r;
   wire at_end = (cnt_r == CW'(CYCLES - 1));

   // ---------------------------------------------------------------
   // any activity rearms; count parks at end so only one pulse
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r <= '0;
      end else if (!idle_i) begin
         cnt_r <= '0;
      end else if (cnt_r != CW'(CYCLES)) begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   assign expired_o = idle_i & at_end;
endmodule : uef_idle_timer

// ===== uef_checker.sv
// assertion checker for the usb device event flag block
`timescale 1ns/1ns
module uef_checker #(
   parameter int SUSPEND_CYCLES = 20
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [uef_pkg::ADR_W-1:0] adr_i,
   input wire logic [uef_pkg::DAT_W-1:0] dat_i,
   input wire logic [uef_pkg::DAT_W-1:0] dat_o,
   input wire logic we_i,
   input wire logic [uef_pkg::SEL_W-1:0] sel_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   input wire logic resume_end_i,
   input wire logic line_activity_i,
   input wire logic bus_reset_done_i,
   input wire logic sof_token_i,
   input wire logic line_idle_j_i,
   input wire logic port_clock_hold_o,
   input wire logic irq_o
);
   import uef_pkg::*;
   // ------------------------------------------------------------
   // mask shadow, idle run length, read tracking
   // ------------------------------------------------------------
   logic [FLAG_W-1:0] mask_r;
   int unsigned idle_r;
   logic rd_clr_r;
   wire logic take = cyc_i && stb_i && !ack_o;
   wire logic run = !port_clock_hold_o;
   wire logic calm = !(resume_end_i || bus_reset_done_i || sof_token_i || line_idle_j_i);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence bus_take;
      take;
   endsequence
   // a set in the same cycle wins, so only calm cycles are judged
   sequence clear_all;
      bus_take ##0 we_i && sel_i[0] && adr_i == OFS_CLEAR && dat_i[5:0] == 6'h3f && calm && run
         && !line_activity_i && !$past(line_activity_i) && !$past(line_idle_j_i);
   endsequence
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mask_r <= MASK_RST;
         idle_r <= '0;
         rd_clr_r <= 1'b0;
      end else begin
         if (take && we_i && sel_i[0] && adr_i == OFS_MASK) begin
            mask_r <= dat_i[FLAG_W-1:0];
         end
         idle_r <= line_idle_j_i ? idle_r + 1 : '0;
         rd_clr_r <= take && !we_i && adr_i == OFS_CLEAR;
      end
   end
   bus_ack_a: assert property (bus_take |=> ack_o)
      else $error("access not acknowledged");
   mask_quiet_a: assert property (mask_r == MASK_RST |-> !irq_o)
      else $error("irq with all masked");
   resume_irq_a: assert property (resume_end_i && mask_r[BIT_RESUME] && run |=> irq_o)
      else $error("resume end no irq");
   reset_irq_a: assert property (bus_reset_done_i && mask_r[BIT_RESET] && run |=> irq_o)
      else $error("reset end no irq");
   frame_irq_a: assert property (sof_token_i && &mask_r[2:1] && run |=> irq_o)
      else $error("frame start no irq");
   idle_irq_a: assert property (idle_r == SUSPEND_CYCLES && mask_r[BIT_SLEEP] && run |-> ##[0:2] irq_o)
      else $error("suspend no irq");
   clear_irq_a: assert property (clear_all |=> !irq_o)
      else $error("flags not cleared");
   clear_read_a: assert property (rd_clr_r |-> ack_o && dat_o == '0)
      else $error("ack register not zero");
endmodule : uef_checker

bind uef_event_flags uef_checker #(.SUSPEND_CYCLES(SUSPEND_CYCLES)) chk_u (.*);

// ===== uef_host_model.sv
// upstream host model driving the link event inputs
`timescale 1ns/1ns
module uef_host_model (
   input wire logic clk_i,
   output logic high_speed_o,
   output logic resume_end_o,
   output logic line_activity_o,
   output logic upstream_resume_o,
   output logic bus_reset_done_o,
   output logic sof_token_o,
   output logic [uef_pkg::FRAME_NUMBER_W-1:0] sof_frame_o,
   output logic line_idle_j_o
);
   import uef_pkg::*;
   // ------------------------------------------------------------
   // event pulses and line states
   // ------------------------------------------------------------
   initial begin
      {high_speed_o, resume_end_o, line_activity_o, upstream_resume_o} = 4'h0;
      {bus_reset_done_o, sof_token_o, line_idle_j_o} = 3'h0;
      sof_frame_o = 11'h7ff;
   end
   // frame number only valid beside its token
   task automatic pulse(input int k, input logic [FRAME_NUMBER_W-1:0] fr);
      resume_end_o <= k == 0;
      bus_reset_done_o <= k == 1;
      sof_token_o <= k == 2;
      sof_frame_o <= fr;
      @(posedge clk_i);
      {resume_end_o, bus_reset_done_o, sof_token_o} <= 3'h0;
      sof_frame_o <= ~fr;
   endtask : pulse
   task automatic lines(input logic hs, input logic act, input logic idle, input logic ures);
      high_speed_o <= hs;
      line_activity_o <= act;
      line_idle_j_o <= idle;
      upstream_resume_o <= ures;
   endtask : lines
endmodule : uef_host_model

// ===== tb_usb_device_event_flags.sv
// self-checking testbench for the usb device event flag block
`timescale 1ns/1ns
module tb_usb_device_event_flags;
   import uef_pkg::*;
   localparam int BUS_IDLE_SLEEP_FLAG = 20;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [ADR_W-1:0] adr_i = 8'h00;
   logic [DAT_W-1:0] dat_i = 32'h0;
   logic [SEL_W-1:0] sel_i = 4'h0;
   logic we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0;
   logic [DAT_W-1:0] dat_o;
   logic ack_o, port_clock_hold_o, irq_o, high_speed_i, resume_end_i, line_activity_i;
   logic upstream_resume_i, bus_reset_done_i, sof_token_i, line_idle_j_i;
   logic [FRAME_NUMBER_W-1:0] sof_frame_i;
   int errors = 0, n_compared = 0;
   int bits[3] = '{BIT_RESUME, BIT_RESET, BIT_FRAME};
   logic [31:0] rnd = 32'h5c;
   // top bits kept clear so a random frame never repeats the fixed ones below
   logic [FRAME_NUMBER_W-1:0] fr_v;
   logic [DAT_W-1:0] exp_q[$];
   always #20 clk_i = ~clk_i;
   uef_event_flags #(.SUSPEND_CYCLES(BUS_IDLE_SLEEP_FLAG), .FILTER_CYCLES(2)) dut_u (.*);
   uef_host_model host_u (.clk_i(clk_i), .high_speed_o(high_speed_i),
      .resume_end_o(resume_end_i), .line_activity_o(line_activity_i),
      .upstream_resume_o(upstream_resume_i), .bus_reset_done_o(bus_reset_done_i),
      .sof_token_o(sof_token_i), .sof_frame_o(sof_frame_i), .line_idle_j_o(line_idle_j_i));
   // ------------------------------------------------------------
   // bus cycles, comparison and verdict
   // ------------------------------------------------------------
   task automatic finish_test;
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : finish_test
   task automatic compare(input logic [DAT_W-1:0] got, input logic [DAT_W-1:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : compare
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      xorshift = v ^ (v << 5);
   endfunction : xorshift
   task automatic check_hold(input logic e);
      @(negedge clk_i);
      compare({31'h0, port_clock_hold_o}, {31'h0, e});
      @(posedge clk_i);
   endtask : check_hold
   task automatic check_irq(input logic e);
      @(negedge clk_i);
      compare({31'h0, irq_o}, {31'h0, e});
      @(posedge clk_i);
   endtask : check_irq
   task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d);
      {cyc_i, stb_i, we_i, sel_i} <= {2'h3, w, 4'hf};
      adr_i <= a;
      dat_i <= d;
      @(posedge clk_i);
      while (ack_o !== 1'b1) @(posedge clk_i);
      {cyc_i, stb_i} <= 2'h0;
      @(posedge clk_i);
   endtask : wb
   task automatic rd(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] e);
      exp_q.push_back(e);
      rnd = xorshift(rnd);
      wb(1'b0, a, rnd);
   endtask : rd
   always @(posedge clk_i) begin
      if (ack_o === 1'b1 && !we_i) compare(dat_o, exp_q.pop_front());
   end
   task automatic act(input logic act_v, input logic idle, input logic ures, input int n);
      host_u.lines(1'b0, act_v, idle, ures);
      repeat (n) @(posedge clk_i);
      host_u.lines(1'b0, 1'b0, 1'b0, 1'b0);
   endtask : act
   initial begin
      repeat (5000) @(posedge clk_i);
      errors++;
      finish_test();
   end
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      for (int a = 0; a <= 32'h14; a += 4) rd(a[7:0], '0);
      wb(1'b1, OFS_MASK, 32'h3f);
      for (int i = 0; i < 3; i++) begin
         fr_v = {3'h0, rnd[7:0]};
         host_u.pulse(i, fr_v);
         check_irq(1'b1);
         wb(1'b1, OFS_CLEAR, 32'h0);
         rd(OFS_STATUS, 32'h1 << bits[i]);
         if (i == 2) rd(OFS_FRAME, {18'h0, fr_v, 3'h0});
         wb(1'b1, OFS_CLEAR, 32'h1 << bits[i]);
         rd(OFS_STATUS, 32'h0);
      end
      wb(1'b1, OFS_MASK, 32'h37);
      host_u.pulse(1, 11'h0);
      check_irq(1'b0);
      wb(1'b1, OFS_MASK, 32'h3f);
      check_irq(1'b1);
      wb(1'b1, OFS_CLEAR, 32'h3f);
      host_u.lines(1'b1, 1'b0, 1'b0, 1'b0);
      host_u.pulse(2, 11'h123);
      rd(OFS_FRAME, 32'h918);
      for (int m = 1; m <= 8; m++) begin
         host_u.pulse(2, 11'h123);
         rd(OFS_FRAME, 32'h918 | 32'(m % 8));
      end
      rd(OFS_STATUS, 32'h6);
      host_u.pulse(2, 11'h124);
      rd(OFS_FRAME, 32'h920);
      wb(1'b1, OFS_CLEAR, 32'h3f);
      rd(OFS_STATUS, 32'h0);
      act(1'b0, 1'b1, 1'b0, BUS_IDLE_SLEEP_FLAG + 4);
      rd(OFS_STATUS, 32'h1);
      act(1'b1, 1'b0, 1'b1, 6);
      rd(OFS_STATUS, 32'h1);
      act(1'b1, 1'b0, 1'b0, 6);
      rd(OFS_STATUS, 32'h10);
      act(1'b0, 1'b1, 1'b0, BUS_IDLE_SLEEP_FLAG + 4);
      rd(OFS_STATUS, 32'h1);
      wb(1'b1, OFS_CLEAR, 32'h1);
      wb(1'b1, OFS_CTRL, 32'h1);
      check_hold(1'b1);
      rd(OFS_CTRL, 32'h1);
      act(1'b1, 1'b0, 1'b0, 6);
      host_u.pulse(1, 11'h0);
      wb(1'b1, OFS_CLEAR, 32'h10);
      rd(OFS_STATUS, 32'h10);
      wb(1'b1, OFS_CTRL, 32'h0);
      check_hold(1'b0);
      wb(1'b1, OFS_CLEAR, 32'h10);
      rd(OFS_STATUS, 32'h0);
      finish_test();
   end
endmodule : tb_usb_device_event_flags
